// File: design/framer_defines.vh
// Purpose: Shared constants for the multichannel output framer
// Assumes: Included once per compile unit by bare name
// Notes:   Definitions only; no logic lives here
`ifndef FRAMER_DEFINES_VH
`define FRAMER_DEFINES_VH

// Framing geometry
`define NCH          8
`define WORD_BITS    24
`define DATA_BITS    16
`define WORD_MSB     5'h17
`define FIFO_DEPTH   8
`define FIFO_WIDTH   20

// Header bit positions inside a 24-bit result word
`define HDR_FATAL    23
`define HDR_NSET     22
`define HDR_REPEAT   21
`define HDR_FTYPE    20
`define HDR_SAT      19

// Gain and result scaling
`define GAIN_FACTORY 24'h555555
`define SCALE_NUM    23'h3FFFFC
`define RESULT_LSB   52
`define RESULT_MAX   16'h7FFF
`define RESULT_MIN   16'h8000

// Register select codes on the register port
`define REG_GAIN_HI  2'h0
`define REG_GAIN_MID 2'h1
`define REG_GAIN_LO  2'h2
`define REG_PHASE    2'h3

// Lane configuration codes from the straps
`define LANE_EIGHT   2'h0
`define LANE_TWO     2'h1

// Decimation codes
`define DEC_32       3'h0
`define DEC_64       3'h1
`define DEC_128      3'h2
`define DEC_256      3'h3
`define DEC_512      3'h4
`define DEC_1024     3'h5

// Results until a channel counts as settled
`define SETTLE_WB    4'h4
`define SETTLE_LL    4'h2

`endif

// File: design/multichannel_adc_output_framer.v
// Purpose: Gain correction, sync phase delay, framing and serial lanes
// Assumes: One 50 MHz clock; bit clock sampled as a plain input
// Notes:   Holds the result FIFO and the top-level framer
`timescale 1ns/1ps
`include "framer_defines.vh"

module result_fifo #(
    parameter WIDTH = 20,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             resetn_i,
    // Filling side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // Draining side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];   // Storage words
    reg [AW-1:0]    wr_ptr;            // Next write slot
    reg [AW-1:0]    rd_ptr;            // Next read slot
    reg [AW:0]      count;             // Words held

    wire push = in_valid_i & in_ready_o;
    wire pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o  = mem[rd_ptr];

    // Storage needs no reset; only pointers define contents
    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and occupancy
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // result_fifo

module multichannel_adc_output_framer (
    // Clock and reset
    input  wire        clk_i,
    input  wire        resetn_i,
    // Straps and pins from outside the clock domain
    input  wire        lane_select_strap_low_i,
    input  wire        lane_select_strap_high_i,
    input  wire        serial_bit_clock_i,
    input  wire        sync_in_i,
    input  wire        ext_clock_present_i,
    input  wire        mem_map_fault_i,
    input  wire        crc_fault_i,
    // Channel configuration, same clock domain
    input  wire        modulator_tick_i,
    input  wire        spi_control_i,
    input  wire [7:0]  filter_low_latency_i,
    input  wire [23:0] decimation_sel_i,
    // Modulator samples, same clock domain
    input  wire        sample_valid_i,
    output reg         sample_ready_o,
    input  wire [2:0]  sample_channel_i,
    input  wire [23:0] sample_value_i,
    input  wire [23:0] sample_offset_i,
    // Register port
    input  wire        reg_write_i,
    input  wire [2:0]  reg_channel_i,
    input  wire [1:0]  reg_select_i,
    input  wire [7:0]  reg_wdata_i,
    output reg  [7:0]  reg_rdata_o,
    // Serial output
    output reg         serial_out_clock_o,
    output reg         frame_ready_n_o,
    output reg  [7:0]  serial_out_lane_o,
    output reg         fatal_error_flag_o
);
    localparam ST_IDLE   = 2'h0;       // Waiting for a complete round
    localparam ST_STROBE = 2'h1;       // Strobe low, header follows
    localparam ST_SHIFT  = 2'h2;       // Bits moving out

    // Delay in modulator periods for one channel's phase setting
    function [9:0] delay_ticks;
        input [2:0] dec;
        input [7:0] ph;
        begin
            case (dec)
                `DEC_32:   delay_ticks = {5'h00, ph[7:3]};
                `DEC_64:   delay_ticks = {4'h0, ph[7:2]};
                `DEC_128:  delay_ticks = {3'h0, ph[7:1]};
                `DEC_256:  delay_ticks = {2'h0, ph};
                `DEC_512:  delay_ticks = {1'b0, ph, 1'b0};
                `DEC_1024: delay_ticks = {ph, 2'h0};
                default:   delay_ticks = 10'h000;
            endcase
        end
    endfunction

    // Two-flop synchronisers; first stage feeds only the second
    reg [6:0] meta;                    // First stage
    reg [6:0] sync2;                   // Second stage, safe to read
    reg       bitclk_d;                // Previous bit clock level
    reg       sync_d;                  // Previous sync level
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta     <= 7'h10;
            sync2    <= 7'h10;
            bitclk_d <= 1'b0;
            sync_d   <= 1'b0;
        end else begin
            meta     <= {crc_fault_i, mem_map_fault_i, ext_clock_present_i,
                         sync_in_i, serial_bit_clock_i,
                         lane_select_strap_high_i, lane_select_strap_low_i};
            sync2    <= meta;
            bitclk_d <= sync2[2];
            sync_d   <= sync2[3];
        end
    end
    wire bit_rise  = sync2[2] & ~bitclk_d;
    wire sync_rise = sync2[3] & ~sync_d;
    wire clk_ok    = sync2[4];

    // Straps taken after the synchronisers settle, then frozen
    reg [1:0] strap_wait;              // Settling count after release
    reg [1:0] lane_mode;               // Captured lane configuration
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strap_wait <= 2'h0;
            lane_mode  <= `LANE_EIGHT;
        end else if (strap_wait != 2'h3) begin
            strap_wait <= strap_wait + 2'h1;
            if (strap_wait == 2'h2) begin
                // Upper strap wins whatever the lower one says
                lane_mode <= sync2[1] ? 2'h2 : {1'b0, sync2[0]};
            end
        end
    end

    // Fatal flag: any fault sets it, only reset clears it
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fatal_error_flag_o <= 1'b0;
        end else if (~clk_ok | sync2[5] | sync2[6]) begin
            fatal_error_flag_o <= 1'b1;
        end
    end

    // Gain and phase registers; reset restores factory gain
    reg [23:0] gain_mem  [0:7];        // Per-channel gain
    reg [7:0]  phase_mem [0:7];        // Per-channel sync phase
    integer i;
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (i = 0; i < `NCH; i = i + 1) begin
                gain_mem[i]  <= `GAIN_FACTORY;
                phase_mem[i] <= 8'h00;
            end
        end else if (reg_write_i) begin
            case (reg_select_i)
                `REG_GAIN_HI:  gain_mem[reg_channel_i][23:16] <= reg_wdata_i;
                `REG_GAIN_MID: gain_mem[reg_channel_i][15:8]  <= reg_wdata_i;
                `REG_GAIN_LO:  gain_mem[reg_channel_i][7:0]   <= reg_wdata_i;
                default:       phase_mem[reg_channel_i]       <= reg_wdata_i;
            endcase
        end
    end

    // Read-back of the selected register byte
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            case (reg_select_i)
                `REG_GAIN_HI:  reg_rdata_o <= gain_mem[reg_channel_i][23:16];
                `REG_GAIN_MID: reg_rdata_o <= gain_mem[reg_channel_i][15:8];
                `REG_GAIN_LO:  reg_rdata_o <= gain_mem[reg_channel_i][7:0];
                default:       reg_rdata_o <= phase_mem[reg_channel_i];
            endcase
        end
    end

    // Scaling arithmetic; one wide multiply chain per sample
    wire signed [24:0] diff   = $signed({sample_value_i[23], sample_value_i})
                              - $signed({sample_offset_i[23], sample_offset_i});
    wire signed [49:0] prod   = diff * $signed({1'b0,
                                                gain_mem[sample_channel_i]});
    wire signed [73:0] scaled = prod * $signed({1'b0, `SCALE_NUM});
    wire        [21:0] whole  = scaled[73:`RESULT_LSB];
    // Fits when the bits above the sign all match it
    wire fits = (whole[21:15] == {7{whole[15]}});
    wire [15:0] clipped = fits ? whole[15:0]
                        : (whole[21] ? `RESULT_MIN : `RESULT_MAX);

    // Stage holding one scaled result until the FIFO takes it
    reg                    stage_valid;
    reg [`FIFO_WIDTH-1:0]  stage_data;  // {channel, saturate, value}
    wire                   fifo_in_ready;
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stage_valid    <= 1'b0;
            stage_data     <= {`FIFO_WIDTH{1'b0}};
            sample_ready_o <= 1'b0;
        end else if (stage_valid) begin
            // Back-pressure: the source waits while the stage is full
            if (fifo_in_ready) begin
                stage_valid    <= 1'b0;
                sample_ready_o <= 1'b1;
            end
        end else if (sample_valid_i & sample_ready_o) begin
            stage_valid    <= 1'b1;
            sample_ready_o <= 1'b0;
            stage_data     <= {sample_channel_i, ~fits, clipped};
        end else begin
            sample_ready_o <= 1'b1;
        end
    end

    wire                  fifo_out_valid;
    wire [`FIFO_WIDTH-1:0] fifo_out_data;
    wire                  fifo_pop_ready;
    result_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (stage_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (stage_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_pop_ready),
        .out_data_o  (fifo_out_data)
    );

    wire [2:0] head_ch = fifo_out_data[19:17];
    reg  [1:0] state;
    reg        round_ready;
    wire       capture = (state == ST_IDLE) & bit_rise & round_ready;
    wire [7:0] fresh;
    wire [7:0] armed;
    wire [`NCH*`WORD_BITS-1:0] round_words;
    // Stall the FIFO rather than overwrite an unsent result
    assign fifo_pop_ready = ~fresh[head_ch] & ~capture;
    wire pop = fifo_out_valid & fifo_pop_ready;

    // Per-channel sync delay, settling and latest result
    genvar g;
    generate
        for (g = 0; g < `NCH; g = g + 1) begin : chan
            reg [9:0]  delay_cnt;      // Modulator periods left
            reg        arm;            // Internal sync has happened
            reg [3:0]  settle;         // Results since internal sync
            reg        have;           // Unsent result waiting
            reg [16:0] held;           // {saturate, value}
            wire [2:0] dec = decimation_sel_i[3*g+2:3*g];
            wire       ll  = filter_low_latency_i[g];
            wire       nset = ~arm | (settle < (ll ? `SETTLE_LL
                                                   : `SETTLE_WB));
            wire       rep  = arm & ~have & spi_control_i;
            assign fresh[g] = have;
            assign armed[g] = arm;
            always @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    delay_cnt <= 10'h000;
                    arm       <= 1'b1;
                    settle    <= 4'h0;
                    have      <= 1'b0;
                    held      <= 17'h00000;
                end else if (sync_rise) begin
                    // Shared sync restarts the filter after its delay
                    delay_cnt <= delay_ticks(dec, phase_mem[g]);
                    arm       <= 1'b0;
                    settle    <= 4'h0;
                    have      <= 1'b0;
                end else begin
                    if (~arm & modulator_tick_i) begin
                        if (delay_cnt == 10'h000) begin
                            arm <= 1'b1;
                        end else begin
                            delay_cnt <= delay_cnt - 10'h001;
                        end
                    end
                    if (pop & (head_ch == g) & arm) begin
                        have <= 1'b1;
                        held <= fifo_out_data[16:0];
                        if (settle != 4'hF) begin
                            settle <= settle + 4'h1;
                        end
                    end else if (capture) begin
                        have <= 1'b0;
                    end
                end
            end
            // Zeros when not yet synced, repeated or clock missing
            wire [15:0] value = (nset & ~arm) | rep | ~clk_ok ? 16'h0000
                              : held[15:0];
            assign round_words[`WORD_BITS*g+`WORD_BITS-1:`WORD_BITS*g] =
                {fatal_error_flag_o, nset, rep, ll, held[16] & ~rep,
                 g[2:0], value};
        end
    endgenerate

    // Round readiness: fastest armed channels all delivered
    reg [2:0] min_dec;
    integer k;
    always @* begin
        min_dec     = `DEC_1024;
        round_ready = |armed;
        for (k = 0; k < `NCH; k = k + 1) begin
            if (armed[k] && decimation_sel_i[3*k+:3] < min_dec) begin
                min_dec = decimation_sel_i[3*k+:3];
            end
        end
        for (k = 0; k < `NCH; k = k + 1) begin
            if (armed[k] && decimation_sel_i[3*k+:3] == min_dec
                    && !fresh[k]) begin
                round_ready = 1'b0;
            end
        end
        // Wideband everywhere waits for the most delayed channel
        if (~|filter_low_latency_i && ~&armed) begin
            round_ready = 1'b0;
        end
        // Otherwise the least delayed armed channel leads
    end

    // Serialiser position
    reg [`NCH*`WORD_BITS-1:0] frame_vec; // Snapshot of one round
    reg [2:0]  word_idx;                 // Result within the lane
    reg [4:0]  bit_idx;                  // Bit within the result
    wire [2:0] last_word = (lane_mode == `LANE_EIGHT) ? 3'h0
                         : (lane_mode == `LANE_TWO) ? 3'h3 : 3'h7;

    // Next bit for each lane at a given position
    reg [2:0] nxt_word;
    reg [4:0] nxt_bit;
    wire [7:0] next_lanes;
    generate
        for (g = 0; g < `NCH; g = g + 1) begin : lane
            wire [2:0] ch = (lane_mode == `LANE_EIGHT) ? g[2:0]
                          : (lane_mode == `LANE_TWO)
                            ? {g[0], nxt_word[1:0]} : nxt_word;
            wire used = (lane_mode == `LANE_EIGHT)
                      | ((lane_mode == `LANE_TWO) & (g < 2)) | (g == 0);
            assign next_lanes[g] = used &
                frame_vec[{ch, 5'h00} - {2'h0, ch, 3'h0} + nxt_bit];
        end
    endgenerate

    // Position that the next bit-clock rise will present
    always @* begin
        nxt_word = word_idx;
        nxt_bit  = bit_idx - 5'h01;
        if (state == ST_STROBE) begin
            nxt_word = 3'h0;
            nxt_bit  = `WORD_MSB;
        end else if (bit_idx == 5'h00) begin
            nxt_word = word_idx + 3'h1;
            nxt_bit  = `WORD_MSB;
        end
    end

    // Output sequencer; every change except the clock copy lands on a bit-clock rise
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state              <= ST_IDLE;
            serial_out_clock_o <= 1'b0;
            frame_ready_n_o    <= 1'b1;
            serial_out_lane_o  <= 8'h00;
            frame_vec          <= {`NCH*`WORD_BITS{1'b0}};
            word_idx           <= 3'h0;
            bit_idx            <= 5'h00;
        end else begin
            // Copy of the sampled clock keeps edges aligned with data
            serial_out_clock_o <= sync2[2];
            if (bit_rise) begin
                case (state)
                    ST_IDLE: begin
                        if (round_ready) begin
                            frame_vec       <= round_words;
                            frame_ready_n_o <= 1'b0;
                            state           <= ST_STROBE;
                        end
                    end
                    ST_STROBE: begin
                        frame_ready_n_o   <= 1'b1;
                        serial_out_lane_o <= next_lanes;
                        word_idx          <= nxt_word;
                        bit_idx           <= nxt_bit;
                        state             <= ST_SHIFT;
                    end
                    ST_SHIFT: begin
                        if (bit_idx == 5'h00 && word_idx == last_word) begin
                            serial_out_lane_o <= 8'h00;
                            state             <= ST_IDLE;
                        end else begin
                            serial_out_lane_o <= next_lanes;
                            word_idx          <= nxt_word;
                            bit_idx           <= nxt_bit;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // multichannel_adc_output_framer

// File: tb/framer_chk.sv
// Purpose: Port-level property checks for the output framer
// Assumes: One clock domain; bound onto the framer's top module
// Notes:   Lane and strobe timing, sticky fault, register read-back
`timescale 1ns/1ps
module framer_chk (
    input logic       clk_i,
    input logic       resetn_i,
    input logic       ext_clock_present_i,
    input logic       reg_write_i,
    input logic [2:0] reg_channel_i,
    input logic [1:0] reg_select_i,
    input logic [7:0] reg_wdata_i,
    input logic [7:0] reg_rdata_o,
    input logic       serial_out_clock_o,
    input logic       frame_ready_n_o,
    input logic [7:0] serial_out_lane_o,
    input logic       fatal_error_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Receiver samples on the falling edge, so moves only at rises
    AST_STROBE_EDGE: assert property ($changed(frame_ready_n_o) |->
        $rose(serial_out_clock_o)) else $error("strobe moved off rise");
    AST_LANE_EDGE: assert property ($changed(serial_out_lane_o) |->
        $rose(serial_out_clock_o)) else $error("lane moved off rise");
    AST_FATAL_STICKY: assert property (fatal_error_flag_o |=>
        fatal_error_flag_o) else $error("fatal flag cleared");
    AST_FATAL_SET: assert property (!ext_clock_present_i |->
        ##[0:6] fatal_error_flag_o) else $error("fatal flag not set");
    AST_STROBE_ONE: assert property ($fell(frame_ready_n_o) |->
        ##[1:20] $rose(frame_ready_n_o)) else $error("strobe too long");
    // Strobe bit period sits ahead of the header, lanes idle
    AST_IDLE_LANES: assert property (!frame_ready_n_o |->
        serial_out_lane_o == 8'h00) else $error("lanes busy at strobe");
    AST_HDR_FATAL: assert property ($rose(frame_ready_n_o) |->
        serial_out_lane_o[0] == fatal_error_flag_o)
        else $error("header fatal bit wrong");
    AST_REG_BACK: assert property (reg_write_i ##1 (!reg_write_i &&
        $stable(reg_select_i) && $stable(reg_channel_i))[*2] |->
        reg_rdata_o == $past(reg_wdata_i, 2)) else $error("read-back wrong");
    cover property ($fell(frame_ready_n_o));
    cover property ($rose(fatal_error_flag_o));
    cover property (reg_write_i);
endmodule // framer_chk

bind multichannel_adc_output_framer framer_chk chk (.clk_i(clk_i),
    .resetn_i(resetn_i), .ext_clock_present_i(ext_clock_present_i),
    .reg_write_i(reg_write_i), .reg_channel_i(reg_channel_i),
    .reg_select_i(reg_select_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .serial_out_clock_o(serial_out_clock_o),
    .frame_ready_n_o(frame_ready_n_o), .serial_out_lane_o(serial_out_lane_o),
    .fatal_error_flag_o(fatal_error_flag_o));

// File: tb/framer_rx_model.sv
// Purpose: Receiver that captures one round from all eight lanes
// Assumes: Bits sampled on the falling edge of the serial clock
// Notes:   Captures a fixed bit count so idle zeros do not shift in
`timescale 1ns/1ps
module framer_rx_model (
    input  logic         sclk_i,
    input  logic         strobe_n_i,
    input  logic [7:0]   lane_i,
    input  logic [7:0]   round_bits_i,
    output logic [7:0]   cnt_o,
    output logic [7:0]   frames_o,
    output logic [191:0] bits_o [8]
);
    initial begin
        cnt_o = 8'hFF;
        frames_o = 8'h00;
    end
    // Opposite edge from the framer's launch edge
    always @(negedge sclk_i) begin
        if (!strobe_n_i) begin
            cnt_o = 8'h00;
            frames_o = frames_o + 8'h01;
            for (int l = 0; l < 8; l++) bits_o[l] = '0;
        end else if (cnt_o < round_bits_i) begin
            for (int l = 0; l < 8; l++) bits_o[l] = {bits_o[l][190:0], lane_i[l]};
            cnt_o = cnt_o + 8'h01;
        end
    end
endmodule // framer_rx_model

// File: tb/multichannel_adc_output_framer_tb.sv
// Purpose: Random rounds per lane code, registers and fault handling
// Assumes: Bit clock free-running at 160 ns, all channels at x32
// Notes:   Settle bit checked on the first round only
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
    error_cnt++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module multichannel_adc_output_framer_tb;
    logic clk_i, resetn_i, strap_lo, strap_hi, sbclk, ext_ok, spi, s_valid;
    logic reg_write_i, sample_ready_o, serial_out_clock_o, frame_ready_n_o;
    logic fatal_o;
    logic [7:0]   llat, reg_wdata_i, reg_rdata_o, lanes, nbits, rx_cnt, rx_fr;
    logic [2:0]   s_ch, reg_channel_i;
    logic [1:0]   reg_select_i;
    logic [23:0]  s_val, s_off;
    logic [191:0] rx_bits [8];
    logic [31:0]  seed;
    int error_cnt, checks_done;
    multichannel_adc_output_framer uut (.clk_i(clk_i), .resetn_i(resetn_i),
        .lane_select_strap_low_i(strap_lo), .lane_select_strap_high_i(strap_hi),
        .serial_bit_clock_i(sbclk), .sync_in_i(1'b0),
        .ext_clock_present_i(ext_ok), .mem_map_fault_i(1'b0),
        .crc_fault_i(1'b0), .modulator_tick_i(1'b0), .spi_control_i(spi),
        .filter_low_latency_i(llat), .decimation_sel_i(24'h000000),
        .sample_valid_i(s_valid), .sample_ready_o(sample_ready_o),
        .sample_channel_i(s_ch), .sample_value_i(s_val),
        .sample_offset_i(s_off), .reg_write_i(reg_write_i),
        .reg_channel_i(reg_channel_i), .reg_select_i(reg_select_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .serial_out_clock_o(serial_out_clock_o),
        .frame_ready_n_o(frame_ready_n_o), .serial_out_lane_o(lanes),
        .fatal_error_flag_o(fatal_o));
    framer_rx_model rx (.sclk_i(serial_out_clock_o),
        .strobe_n_i(frame_ready_n_o), .lane_i(lanes), .round_bits_i(nbits),
        .cnt_o(rx_cnt), .frames_o(rx_fr), .bits_o(rx_bits));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // 6.25 MHz covers 8 channels x 24 bits at one lane
    initial begin
        sbclk = 1'b0;
        #7;
        forever #80 sbclk = ~sbclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // Expected result word: gain 0x555555, scale 4194300 / 2^52
    function automatic logic [23:0] expw(input int c, input logic [23:0] v,
        input logic [23:0] o, input logic f, input logic z);
        logic signed [79:0] p;
        logic s;
        logic [15:0] d;
        p = $signed(v) - $signed(o);
        p = (p * 80'sh555555 * 80'sd4194300) >>> 52;
        s = p > 32767 || p < -32768;
        d = z ? 16'h0000 : (s ? (p < 0 ? 16'h8000 : 16'h7FFF) : p[15:0]);
        return {f, 2'b00, llat[c], s, c[2:0], d};
    endfunction
    task automatic rst(input logic [1:0] st);
        @(negedge clk_i);
        resetn_i = 1'b0;
        {strap_hi, strap_lo} = st;
        seed = xs(seed);
        {spi, llat} = seed[8:0];
        repeat (4) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (8) @(negedge clk_i);
    endtask
    task automatic rdchk(input logic [2:0] c, input logic [1:0] s,
        input logic [7:0] e);
        @(negedge clk_i);
        reg_channel_i = c;
        reg_select_i = s;
        repeat (2) @(negedge clk_i);
        `CHK("reg", e, reg_rdata_o)
    endtask
    task automatic send(input logic [2:0] c, input logic [23:0] v, o);
        int n = 0;
        @(negedge clk_i);
        {s_ch, s_val, s_off, s_valid} = {c, v, o, 1'b1};
        while (sample_ready_o !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 400) error_cnt++;
        @(negedge clk_i);
        s_valid = 1'b0;
    endtask
    // One round: eight samples in, then every lane decoded
    task automatic round(input logic [1:0] st, input logic f, z, first);
        logic [23:0] v [8], o [8], e, w;
        logic [7:0] fr;
        int cpl, n, c;
        cpl = st[1] ? 8 : (st[0] ? 4 : 1);
        nbits = 8'(24 * cpl);
        fr = rx_fr;
        for (c = 0; c < 8; c++) begin
            seed = xs(seed);
            v[c] = (c == 3) ? 24'h800000 : seed[23:0];
            seed = xs(seed);
            o[c] = {{8{seed[15]}}, seed[15:0]};
            send(3'(c), v[c], o[c]);
        end
        n = 0;
        while ((rx_fr == fr || rx_cnt != nbits) && n < 6000) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 6000) error_cnt++;
        for (int l = 0; l < 8; l++) for (int k = 0; k < cpl; k++) begin
            c = st[1] ? k : (st[0] ? 4 * l + k : l);
            w = rx_bits[l][24 * cpl - 1 - 24 * k -: 24];
            e = (l >= 8 / cpl) ? 24'h0 : expw(c, v[c], o[c], f, z);
            `CHK("word", e, w & 24'hBFFFFF)
        end
        if (first) `CHK("unsettled", 1'b1, rx_bits[0][24 * cpl - 2])
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_i);
        error_cnt++;
        $display("watchdog expired");
        give_verdict;
    end
    initial begin
        {resetn_i, strap_lo, strap_hi, ext_ok, spi, s_valid} = 6'b000100;
        {llat, reg_wdata_i, s_ch, s_val, s_off} = '0;
        {reg_write_i, reg_channel_i, reg_select_i, nbits} = '0;
        seed = 32'd97;
        error_cnt = 0;
        checks_done = 0;
        rst(2'b00);
        for (int s = 0; s < 4; s++) rdchk(3'(s * 2), 2'(s), s == 3 ? 8'h00 : 8'h55);
        seed = xs(seed);
        @(negedge clk_i);
        {reg_write_i, reg_channel_i, reg_select_i, reg_wdata_i} =
            {1'b1, 3'h5, 2'h1, seed[7:0]};
        @(negedge clk_i);
        reg_write_i = 1'b0;
        rdchk(3'h5, 2'h1, seed[7:0]);
        for (int st = 0; st < 4; st++) begin
            rst(2'(st));
            // Strap changes after capture must be ignored
            {strap_hi, strap_lo} = ~2'(st);
            rdchk(3'h5, 2'h1, 8'h55);
            round(2'(st), 1'b0, 1'b0, 1'b1);
            round(2'(st), 1'b0, 1'b0, 1'b0);
        end
        ext_ok = 1'b0;
        repeat (10) @(negedge clk_i);
        round(2'b11, 1'b1, 1'b1, 1'b0);
        ext_ok = 1'b1;
        repeat (10) @(negedge clk_i);
        round(2'b11, 1'b1, 1'b0, 1'b0);
        rst(2'b00);
        `CHK("fatal", 1'b0, fatal_o)
        give_verdict;
    end
endmodule // multichannel_adc_output_framer_tb
